// ==== core/smf_pkg.sv ====
// Package for the switch mode and fault logic: widths, encodings, timing
package smf_pkg;
	localparam int SMF_NUM_HS = 4;
	localparam int SMF_NUM_LS = 8;
	localparam int SMF_NUM_OUT = 12;
	localparam int SMF_HS_ZERO = 0;
	localparam int SMF_HS_TWO = 2;
	localparam int SMF_LS_BASE = 4;
	// Fault filter time in ns and its cycle count at 20 MHz
	localparam int SMF_CLK_PERIOD_NS = 50;
	localparam int SMF_FILTER_NS = 300;
	localparam int SMF_FILTER_CYC = (SMF_FILTER_NS + SMF_CLK_PERIOD_NS - 1)
		/ SMF_CLK_PERIOD_NS;
	localparam logic [11:0] SMF_ALL_ZERO = 12'h000;
	localparam logic [11:0] SMF_ALL_ONE = 12'hFFF;
	localparam logic [3:0] SMF_HS_NONE = 4'h0;
	localparam logic [7:0] SMF_LS_NONE = 8'h00;
	localparam logic [3:0] SMF_FAILSAFE_HS = 4'h5;

	typedef enum logic [1:0] {
		SMF_SLEEP = 2'b00,
		SMF_OFF = 2'b01,
		SMF_NORMAL = 2'b10,
		SMF_FAILSAFE = 2'b11
	} smf_mode_type;

	// Configuration words loaded by the serial front end
	typedef struct packed {
		logic [11:0] output_cmd;
		logic [11:0] direct_select;
		logic [11:0] openload_config_reg;
		logic [7:0] overcurrent_shutdown_reg;
	} smf_cfg_type;

	// Raw analog sensing per output; overvoltage is one global bit
	typedef struct packed {
		logic [11:0] overtemp;
		logic [11:0] openload;
		logic [7:0] overcurrent;
		logic overvoltage;
		logic [11:0] cooled;
	} smf_sense_type;
endpackage

// ==== core/smf_core.sv ====
// Mode sequencing and fault handling for the twelve power switches
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Until configured, low-sides follow shared input, high-sides own inputs.
// - Default: high-side open-load detection on, low-side off.
// - Wake low and reset low: sleep, all outputs off.
// - Wake high, reset low, no timeout: all off; reset rise gives default.
// - Wake high, reset low, timeout: fail-safe, leave by dropping wake.
// - Reset high, timeout: fail-safe; leave by dropping reset and wake.
// - Reset high, no timeout: normal, outputs from config and inputs.
// - Every detected fault latches a 1 in its output's status bit.
// - Vanished faults clear their status bit on chip-select rise.
// - Overtemp and open-load per output, overvoltage global, overcurrent LS.
// - Low-side overcurrent and open-load pass a fault delay filter.
// - Flag low on any fault; overvoltage, HS faults tracked live.
// - LS faults latch flag low; toggling output or reset clears.
// - Overtemp only sensed when on; shuts only the affected output.
// - Low-side overtemp latches off until commanded off after cooling.
// - High-side overtemp off, back on automatically after cooling.
// - Overvoltage turns all outputs off and latches fault for all.
// - After overvoltage all twelve status bits read 1 until cleared.
// - Open-load only when off; enabled by 0 for HS, 1 for LS.
// - HS open-load clearable once load restored or commanded on.
// - Enabled LS overcurrent: filter timer, then off and latch fault.
// - LS overcurrent retry only after off then on command.
// - Disabled LS overcurrent: stay in current limit, no report.
// - Fail-safe select low disables watchdog and fail-safe behaviour.
// - Status bits 11 to 0 map to outputs of same number.
module smf_core
	import smf_pkg::*;
#(
	parameter int FILTER_CYC = SMF_FILTER_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wake,
	input wire logic watchdog_expired,
	input wire logic failsafe_select_in,
	input wire logic low_side_direct_in,
	input wire logic [3:0] high_side_direct_in,
	input wire logic cfg_valid,
	input wire smf_cfg_type cfg_in,
	input wire logic chip_select_rise,
	input wire smf_sense_type sense,
	output logic [3:0] high_switches,
	output logic [7:0] low_switches,
	output logic [11:0] output_fault_bits,
	output logic fault_flag_n,
	output smf_mode_type mode
);

	localparam int CW = $clog2(FILTER_CYC + 1);
	localparam logic [CW-1:0] FILT_MAX = CW'(FILTER_CYC);

	smf_cfg_type cfg;
	logic was_default;
	logic [11:0] cmd_on;
	logic [11:0] cmd_on_prev;
	logic [11:0] drive;
	logic [3:0] hs_on_cmd;
	logic [11:0] ol_enabled;
	logic [11:0] ol_raw;
	logic [11:0] ot_raw;
	logic [7:0] oc_raw;
	logic [7:0] ls_ol_ok;
	logic [7:0] ls_oc_ok;
	logic [7:0] ls_off_latch;
	logic [7:0] ls_flag_latch;
	logic [11:0] fault_now;
	logic [11:0] status;
	logic [11:0] next_status;
	logic fs_active;
	logic ov;
	logic next_flag_n;
	smf_mode_type next_mode;

	// Watchdog timeout only acts when fail-safe select is high
	assign fs_active = failsafe_select_in & watchdog_expired;
	assign ov = sense.overvoltage;

	// Mode from pin levels; timeout input is held outside until exit
	assign next_mode = (!wake && !rst_b) ? SMF_SLEEP :
		fs_active ? SMF_FAILSAFE :
		!rst_b ? SMF_OFF : SMF_NORMAL;

	// Output command: direct inputs steer until configured
	generate
		for (genvar i = 0; i < SMF_NUM_OUT; i++) begin : g_cmd
			logic din;
			if (i < SMF_LS_BASE) begin : g_hs
				assign din = high_side_direct_in[i];
			end else begin : g_ls
				assign din = low_side_direct_in;
			end
			assign cmd_on[i] = cfg.direct_select[i] ? din :
				(cfg.output_cmd[i] | (was_default & din));
		end
	endgenerate

	// Open-load enables, polarity differs per side
	assign ol_enabled = {cfg.openload_config_reg[11:4],
		~cfg.openload_config_reg[3:0]};
	assign ol_raw = sense.openload & ol_enabled & ~drive;
	// High-side thermal sense follows the command, not the gated drive;
	// otherwise the shutdown would mask its own fault report
	assign hs_on_cmd = (mode == SMF_NORMAL && !ov) ? cmd_on[3:0] :
		SMF_HS_NONE;
	assign ot_raw = sense.overtemp & {drive[11:4], hs_on_cmd};
	assign oc_raw = sense.overcurrent & drive[11:4] &
		cfg.overcurrent_shutdown_reg;

	// Low-side filters and latches, one per low-side output
	generate
		for (genvar j = 0; j < SMF_NUM_LS; j++) begin : g_ls
			localparam int K = j + SMF_LS_BASE;
			logic [CW-1:0] oc_cnt;
			logic [CW-1:0] ol_cnt;
			logic toggled;
			logic off_latch;
			logic flag_latch;
			// Local latches, exported bitwise so one process owns each
			assign ls_off_latch[j] = off_latch;
			assign ls_flag_latch[j] = flag_latch;
			assign toggled = cmd_on[K] ^ cmd_on_prev[K];
			assign ls_oc_ok[j] = (oc_cnt == FILT_MAX);
			assign ls_ol_ok[j] = (ol_cnt == FILT_MAX);
			// Counters reset when condition drops so glitches vanish
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					oc_cnt <= '0;
					ol_cnt <= '0;
					off_latch <= 1'b0;
					flag_latch <= 1'b0;
				end else begin
					oc_cnt <= !oc_raw[j] ? '0 :
						(ls_oc_ok[j] ? oc_cnt : oc_cnt + 1'b1);
					ol_cnt <= !ol_raw[K] ? '0 :
						(ls_ol_ok[j] ? ol_cnt : ol_cnt + 1'b1);
					// Latched off until commanded off; retry on new on
					if (ls_oc_ok[j] || ot_raw[K])
						off_latch <= 1'b1;
					else if (!cmd_on[K] && !sense.overtemp[K])
						off_latch <= 1'b0;
					// Set wins over toggle clear
					if (ls_oc_ok[j] || ls_ol_ok[j] || ot_raw[K])
						flag_latch <= 1'b1;
					else if (toggled)
						flag_latch <= 1'b0;
				end
			end
		end
	endgenerate

	// Actual drive: mode, overvoltage, thermal and latch gating
	always_comb begin
		drive = SMF_ALL_ZERO;
		case (mode)
			SMF_NORMAL: begin
				drive[3:0] = cmd_on[3:0] & ~sense.overtemp[3:0];
				drive[11:4] = cmd_on[11:4] & ~ls_off_latch;
			end
			SMF_FAILSAFE: drive[3:0] = SMF_FAILSAFE_HS;
			default: drive = SMF_ALL_ZERO;
		endcase
		// Overvoltage overrides every mode, fail-safe included
		if (ov)
			drive = SMF_ALL_ZERO;
	end

	// Present fault per output; overvoltage hits every bit
	assign fault_now = {ls_oc_ok | ls_ol_ok, ol_raw[3:0]} |
		ot_raw | {SMF_NUM_OUT{ov}};

	// Latched status; on chip-select rise keep only live faults
	assign next_status = chip_select_rise ? fault_now :
		(status | fault_now);

	assign next_flag_n = ~(ov | (|ol_raw[3:0]) | (|ot_raw[3:0]) |
		(|ls_flag_latch));

	// Configuration held at default whenever reset pin is low
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= '0;
			was_default <= 1'b1;
		end else if (cfg_valid) begin
			cfg <= cfg_in;
			was_default <= 1'b0;
		end
	end

	// Status, flag, previous-command and fault-bit registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status <= SMF_ALL_ZERO;
			cmd_on_prev <= SMF_ALL_ZERO;
			fault_flag_n <= 1'b1;
			output_fault_bits <= SMF_ALL_ZERO;
		end else begin
			status <= next_status;
			cmd_on_prev <= cmd_on;
			fault_flag_n <= next_flag_n;
			output_fault_bits <= next_status;
		end
	end

	// Switch pins are not cleared by the reset pin: with reset low and a
	// timeout the fail-safe pair must still be driven on
	always_ff @(posedge clk) begin
		high_switches <= drive[3:0];
		low_switches <= drive[11:4];
	end

	// Mode register runs through reset so sleep and fail-safe show
	always_ff @(posedge clk) begin
		mode <= next_mode;
	end

	chk_failsafe_drive: assert property (@(posedge clk)
		(mode == SMF_FAILSAFE) |=> (high_switches == SMF_FAILSAFE_HS)
			&& (low_switches == SMF_LS_NONE))
		else $error("fail-safe outputs wrong");

	chk_sleep_off: assert property (@(posedge clk)
		(mode == SMF_SLEEP || mode == SMF_OFF) |=>
			(high_switches == SMF_HS_NONE) && (low_switches == SMF_LS_NONE))
		else $error("outputs on while sleeping");

	chk_fsi_disable: assert property (@(posedge clk)
		!failsafe_select_in |=> mode != SMF_FAILSAFE)
		else $error("fail-safe with select low");

	chk_ov_all_off: assert property (@(posedge clk) disable iff (!rst_b)
		ov |=> (low_switches == SMF_LS_NONE) &&
			(output_fault_bits == SMF_ALL_ONE))
		else $error("overvoltage not handled");

	chk_fault_sticky: assert property (@(posedge clk) disable iff (!rst_b)
		(status[0] && !chip_select_rise) |=> status[0])
		else $error("status bit lost without clear");

	chk_flag_ov: assert property (@(posedge clk) disable iff (!rst_b)
		ov |=> !fault_flag_n)
		else $error("flag not low on overvoltage");

	chk_cs_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(chip_select_rise && fault_now == SMF_ALL_ZERO) |=>
			status == SMF_ALL_ZERO)
		else $error("status not cleared");

	chk_ls_ot_off: assert property (@(posedge clk) disable iff (!rst_b)
		(mode == SMF_NORMAL && ot_raw[4]) ##1 (mode == SMF_NORMAL) |=>
			!low_switches[0])
		else $error("low-side on after overtemp");

	chk_oc_filter: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(oc_raw[0]) |-> !ls_oc_ok[0])
		else $error("overcurrent accepted unfiltered");

	// Mode decoding from pin levels
	chk_sleep_mode: assert property (@(posedge clk)
		(!wake && !rst_b) |=> mode == SMF_SLEEP)
		else $error("not in sleep with wake and reset low");

	chk_mode_off: assert property (@(posedge clk)
		(wake && !rst_b && !fs_active) |=> mode == SMF_OFF)
		else $error("not all-off with reset low");

	chk_fs_mode: assert property (@(posedge clk)
		(fs_active && (wake || rst_b)) |=> mode == SMF_FAILSAFE)
		else $error("fail-safe not entered");

	chk_mode_normal: assert property (@(posedge clk)
		(rst_b && !fs_active) |=> mode == SMF_NORMAL)
		else $error("normal mode not entered");

	// Overvoltage wins over fail-safe too
	chk_ov_hs_off: assert property (@(posedge clk)
		ov |=> high_switches == SMF_HS_NONE)
		else $error("high-side on during overvoltage");

	// Thermal behaviour of single outputs
	chk_hs_ot_off: assert property (@(posedge clk)
		sense.overtemp[1] |=> !high_switches[1])
		else $error("high-side on during overtemp");

	chk_hs_recover: assert property (@(posedge clk) disable iff (!rst_b)
		(mode == SMF_NORMAL && !ov && cmd_on[1] && !sense.overtemp[1]) |=>
			high_switches[1])
		else $error("high-side did not recover");

	chk_ls_latch_hold: assert property (@(posedge clk) disable iff (!rst_b)
		ls_off_latch[0] |=> !low_switches[0])
		else $error("latched low-side driven");

	// Fault capture and reporting
	chk_oc_latch: assert property (@(posedge clk) disable iff (!rst_b)
		ls_oc_ok[0] |=> output_fault_bits[4] && ls_off_latch[0])
		else $error("overcurrent not latched");

	chk_oc_disabled: assert property (@(posedge clk) disable iff (!rst_b)
		(!cfg.overcurrent_shutdown_reg[0] ##1
			!cfg.overcurrent_shutdown_reg[0]) |-> !ls_oc_ok[0])
		else $error("overcurrent reported while disabled");

	chk_ol_status: assert property (@(posedge clk) disable iff (!rst_b)
		ol_raw[0] |=> output_fault_bits[0])
		else $error("open-load not reported");

	chk_cs_keep_live: assert property (@(posedge clk) disable iff (!rst_b)
		(chip_select_rise && fault_now[1]) |=> status[1])
		else $error("live fault cleared");

	chk_flag_ls_latch: assert property (@(posedge clk) disable iff (!rst_b)
		ls_flag_latch[0] |=> !fault_flag_n)
		else $error("flag high with low-side latch set");

	chk_flag_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(!ov && ol_raw[3:0] == SMF_HS_NONE && ot_raw[3:0] == SMF_HS_NONE &&
			ls_flag_latch == SMF_LS_NONE) |=> fault_flag_n)
		else $error("flag low with no fault");

	chk_toggle_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd_on[4] != cmd_on_prev[4] && !ls_oc_ok[0] && !ls_ol_ok[0] &&
			!ot_raw[4]) |=> !ls_flag_latch[0])
		else $error("flag latch kept after toggle");

endmodule // smf_core

`default_nettype wire

// ==== testbench/smf_host.sv ====
// Host model: loads configuration words and pulses chip-select rise
`timescale 1ns/1ns
`default_nettype none
module smf_host
	import smf_pkg::*;
(
	input wire logic clk,
	output logic cfg_valid,
	output smf_cfg_type cfg_in,
	output logic chip_select_rise
);
	initial begin
		cfg_valid = 1'b0;
		cfg_in = '0;
		chip_select_rise = 1'b0;
	end
	// One-cycle load pulse; word kept so the port never floats
	task automatic load(input logic [11:0] cmd, input logic [7:0] ocs);
		@(posedge clk) #5;
		// Test loads stay unconnected, so open-load sensing is off
		cfg_in = '{cmd, 12'h000, 12'h00F, ocs};
		cfg_valid = 1'b1;
		@(posedge clk) #5;
		cfg_valid = 1'b0;
	endtask
	// Frame end as seen by the fault logic
	task automatic cs_rise;
		@(posedge clk) #5;
		chip_select_rise = 1'b1;
		@(posedge clk) #5;
		chip_select_rise = 1'b0;
	endtask
endmodule // smf_host
`default_nettype wire

// ==== testbench/switch_mode_fault_logic_test.sv ====
// Self-checking bench for the switch mode and fault logic
`timescale 1ns/1ns
`default_nettype none
module switch_mode_fault_logic_test
	import smf_pkg::*;
;
	localparam int FILT = 2;
	logic clk, rst_b, wake, watchdog_expired, failsafe_select_in;
	logic low_side_direct_in, cfg_valid, chip_select_rise, fault_flag_n;
	logic [3:0] high_side_direct_in, high_switches;
	logic [7:0] low_switches;
	logic [11:0] output_fault_bits;
	smf_cfg_type cfg_in;
	smf_sense_type sense;
	smf_mode_type mode;
	int failures, checks_done;
	smf_core #(.FILTER_CYC(FILT)) dut(.clk(clk), .rst_b(rst_b),
		.wake(wake), .watchdog_expired(watchdog_expired),
		.failsafe_select_in(failsafe_select_in),
		.low_side_direct_in(low_side_direct_in),
		.high_side_direct_in(high_side_direct_in), .cfg_valid(cfg_valid),
		.cfg_in(cfg_in), .chip_select_rise(chip_select_rise),
		.sense(sense), .high_switches(high_switches),
		.low_switches(low_switches), .output_fault_bits(output_fault_bits),
		.fault_flag_n(fault_flag_n), .mode(mode));
	smf_host host(.clk(clk), .cfg_valid(cfg_valid), .cfg_in(cfg_in),
		.chip_select_rise(chip_select_rise));
	// Inputs move 5 ns after the edge, away from sampling
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic chk(input string what, input logic [11:0] exp,
		input logic [11:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic outs(input logic [3:0] hs, input logic [7:0] ls);
		chk("high_switches", {8'h00, hs}, {8'h00, high_switches});
		chk("low_switches", {4'h0, ls}, {4'h0, low_switches});
	endtask
	task automatic flt(input logic [11:0] bits, input logic flag);
		chk("output_fault_bits", bits, output_fault_bits);
		chk("fault_flag_n", {11'h000, flag}, {11'h000, fault_flag_n});
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Hang guard, far beyond the 86 or so cycles used
	initial begin
		#200000;
		failures++;
		conclude;
	end
	initial begin
		{rst_b, wake, watchdog_expired, low_side_direct_in} = 4'h0;
		failsafe_select_in = 1'b1;
		high_side_direct_in = 4'h0;
		sense = '0;
		failures = 0;
		checks_done = 0;
		step(3);
		rst_b = 1'b1;
		high_side_direct_in = 4'hA;
		low_side_direct_in = 1'b1;
		step(3);
		outs(4'hA, 8'hFF);
		flt(12'h000, 1'b1);
		{high_side_direct_in, low_side_direct_in} = 5'h00;
		sense.openload = 12'h011;
		step(3);
		flt(12'h001, 1'b0);
		sense.openload = 12'h000;
		step(3);
		chk("fault_flag_n", 12'h001, {11'h000, fault_flag_n});
		host.cs_rise();
		step(2);
		flt(12'h000, 1'b1);
		$display("test default done");
		host.load(12'h010, 8'h01);
		step(3);
		outs(4'h0, 8'h01);
		sense.overcurrent = 8'h01;
		step(FILT + 3);
		outs(4'h0, 8'h00);
		flt(12'h010, 1'b0);
		sense.overcurrent = 8'h00;
		host.cs_rise();
		step(2);
		flt(12'h000, 1'b0);
		host.load(12'h000, 8'h01);
		host.load(12'h010, 8'h01);
		step(3);
		outs(4'h0, 8'h01);
		chk("fault_flag_n", 12'h001, {11'h000, fault_flag_n});
		$display("test overcurrent done");
		sense.overtemp = 12'h010;
		step(3);
		outs(4'h0, 8'h00);
		flt(12'h010, 1'b0);
		sense.overtemp = 12'h000;
		step(3);
		outs(4'h0, 8'h00);
		host.cs_rise();
		host.load(12'h000, 8'h01);
		host.load(12'h012, 8'h01);
		sense.overtemp = 12'h002;
		step(3);
		outs(4'h0, 8'h01);
		flt(12'h002, 1'b0);
		sense.overtemp = 12'h000;
		step(3);
		outs(4'h2, 8'h01);
		chk("fault_flag_n", 12'h001, {11'h000, fault_flag_n});
		sense.overvoltage = 1'b1;
		step(3);
		outs(4'h0, 8'h00);
		flt(12'hFFF, 1'b0);
		sense.overvoltage = 1'b0;
		host.cs_rise();
		step(2);
		chk("output_fault_bits", 12'h000, output_fault_bits);
		$display("test thermal and overvoltage done");
		failsafe_select_in = 1'b0;
		watchdog_expired = 1'b1;
		step(3);
		chk("high_switches", 12'h002, {8'h00, high_switches});
		failsafe_select_in = 1'b1;
		step(3);
		outs(4'h5, 8'h00);
		high_side_direct_in = 4'h8;
		rst_b = 1'b0;
		watchdog_expired = 1'b0;
		step(3);
		outs(4'h0, 8'h00);
		rst_b = 1'b1;
		step(3);
		outs(4'h8, 8'h00);
		wake = 1'b1;
		rst_b = 1'b0;
		watchdog_expired = 1'b1;
		step(3);
		outs(4'h5, 8'h00);
		wake = 1'b0;
		step(3);
		outs(4'h0, 8'h00);
		watchdog_expired = 1'b0;
		wake = 1'b1;
		step(3);
		outs(4'h0, 8'h00);
		rst_b = 1'b1;
		step(3);
		outs(4'h8, 8'h00);
		$display("test modes done");
		conclude;
	end
endmodule // switch_mode_fault_logic_test
`default_nettype wire
